// File: rtl/fcrc_scanner.v
// Flash CRC memory scanner: control, flash fetch and result logic
`timescale 1ns/1ps
`include "fcrc_regs.vh"

module fcrc_scanner (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        enable_wr,
  input  wire        source_select_wr,
  input  wire [1:0]  source_select_wdata,
  input  wire        nmi_enable_wr,
  input  wire [1:0]  boot_scan_fuse_field,
  input  wire [7:0]  boot_end_page,
  input  wire [7:0]  app_end_page,
  input  wire        cpu_sleep,
  output wire        flash_rd_en,
  output wire [14:0] flash_word_addr,
  input  wire [15:0] flash_rdata,
  output wire        cpu_stall,
  output wire        cpu_reset_hold,
  output wire        enable,
  output wire [1:0]  source_select,
  output wire        nonmaskable_irq_enable,
  output wire        busy,
  output wire        pass,
  output wire        nmi_req
);

  localparam ST_INIT  = 2'b00;
  localparam ST_IDLE  = 2'b01;
  localparam ST_DELAY = 2'b10;
  localparam ST_SCAN  = 2'b11;

  reg [1:0]  state_r;
  reg [1:0]  delay_r;
  reg [1:0]  phase_r;
  reg [14:0] ptr_r;
  reg [15:0] crc_r;
  reg [7:0]  hi_r;
  reg        enable_r;
  reg [1:0]  src_r;
  reg        nmi_en_r;
  reg        busy_r;
  reg        pass_r;
  reg        nmi_r;
  reg        hold_r;
  reg        boot_r;

  wire [15:0] crc_nxt;
  wire [7:0]  crc_byte;
  wire [14:0] region_end;
  wire        halt;
  wire        last_word;
  wire        match;
  wire        wr_ok;

  // =====================================================================
  // Region end as a word index
  function [14:0] end_word;
    input [1:0] src;
    input [7:0] boot_pg;
    input [7:0] app_pg;
    reg   [15:0] last_byte;
    begin
      last_byte = `FCRC_FLASH_END;
      case (src)
        `FCRC_SRC_BOOT:    last_byte = {boot_pg, `FCRC_PAGE_LSB} - `FCRC_ONE_BYTE;
        `FCRC_SRC_BOOTAPP: last_byte = {app_pg, `FCRC_PAGE_LSB} - `FCRC_ONE_BYTE;
        default:           last_byte = `FCRC_FLASH_END;
      endcase
      end_word = last_byte[15:1];
    end
  endfunction

  // =====================================================================
  // Byte datapath
  // low byte of each word first, then high byte
  assign crc_byte  = (phase_r == `FCRC_PH_LOW) ? flash_rdata[7:0] : hi_r;
  assign region_end = end_word(src_r, boot_end_page, app_end_page);
  assign last_word = (ptr_r == region_end);
  // stored checksum leaves a zero residue
  assign match     = (crc_nxt == `FCRC_RESIDUE);

  fcrc_crc16_byte u_crc (
    .crc_in  (crc_r),
    .data_in (crc_byte),
    .crc_out (crc_nxt)
  );

  // pause only between fetches
  // Sleep mid-word lets the current word finish
  assign halt  = cpu_sleep && (phase_r == `FCRC_PH_ISSUE);
  // Writes locked while busy or once an interrupt request stands
  assign wr_ok = !busy_r && !nmi_r;

  // =====================================================================
  // Outputs
  // one word fetch per three cycles
  assign flash_rd_en            = (state_r == ST_SCAN) && (phase_r == `FCRC_PH_ISSUE) && !halt;
  assign flash_word_addr        = ptr_r;
  assign cpu_stall              = (state_r == ST_SCAN);
  assign cpu_reset_hold         = hold_r;
  assign enable                 = enable_r;
  assign source_select          = src_r;
  assign nonmaskable_irq_enable = nmi_en_r;
  assign busy                   = busy_r;
  assign pass                   = pass_r;
  assign nmi_req                = nmi_r;

  // =====================================================================
  // Control state machine
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_INIT;
      delay_r  <= 2'h0;
      phase_r  <= `FCRC_PH_ISSUE;
      ptr_r    <= `FCRC_WORD_ZERO;
      crc_r    <= `FCRC_INIT;
      hi_r     <= 8'h00;
      enable_r <= 1'b0;
      src_r    <= `FCRC_SRC_BOOTAPP;
      nmi_en_r <= 1'b0;
      busy_r   <= 1'b0;
      pass_r   <= 1'b0;
      nmi_r    <= 1'b0;
      hold_r   <= 1'b1;
      boot_r   <= 1'b0;
    end else begin
      case (state_r)
        ST_INIT: begin
          // fuse sampled after reset release
          // Fuse field is static, so no synchroniser before this read
          if (boot_scan_fuse_field != `FCRC_FUSE_NONE) begin
            src_r    <= boot_scan_fuse_field;
            enable_r <= 1'b1;
            busy_r   <= 1'b1;
            boot_r   <= 1'b1;
            crc_r    <= `FCRC_INIT;
            ptr_r    <= `FCRC_WORD_ZERO;
            phase_r  <= `FCRC_PH_ISSUE;
            state_r  <= ST_SCAN;
          end else begin
            hold_r  <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (source_select_wr && wr_ok) begin
            src_r <= source_select_wdata;
          end
          // enable only settable, cleared by reset
          if (nmi_enable_wr && wr_ok) begin
            nmi_en_r <= 1'b1;
          end
          if (enable_wr && wr_ok) begin
            enable_r <= 1'b1;
            busy_r   <= 1'b1;
            delay_r  <= 2'h0;
            state_r  <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (!cpu_sleep) begin
            if (delay_r == `FCRC_DELAY_LAST) begin
              crc_r   <= `FCRC_INIT;
              ptr_r   <= `FCRC_WORD_ZERO;
              phase_r <= `FCRC_PH_ISSUE;
              state_r <= ST_SCAN;
            end else begin
              delay_r <= delay_r + 2'h1;
            end
          end
        end
        ST_SCAN: begin
          if (!halt) begin
            case (phase_r)
              `FCRC_PH_ISSUE: begin
                phase_r <= `FCRC_PH_LOW;
              end
              `FCRC_PH_LOW: begin
                crc_r   <= crc_nxt;
                hi_r    <= flash_rdata[15:8];
                phase_r <= `FCRC_PH_HIGH;
              end
              default: begin
                crc_r   <= crc_nxt;
                phase_r <= `FCRC_PH_ISSUE;
                if (last_word) begin
                  // busy and pass settle at completion
                  busy_r  <= 1'b0;
                  pass_r  <= match;
                  boot_r  <= 1'b0;
                  state_r <= ST_IDLE;
                  // CPU released only on pass
                  // A failed start-up scan keeps the hold until reset
                  if (boot_r && match) begin
                    hold_r <= 1'b0;
                  end
                  if (!match && nmi_en_r) begin
                    nmi_r <= 1'b1;
                  end
                end else begin
                  ptr_r <= ptr_r + `FCRC_WORD_ONE;
                end
              end
            endcase
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: rtl/fcrc_regs.vh
// Constants for the flash CRC memory scanner
`ifndef FCRC_REGS_VH
`define FCRC_REGS_VH

// =====================================================================
// CRC arithmetic
`define FCRC_POLY        16'h1021
`define FCRC_INIT        16'hFFFF
`define FCRC_RESIDUE     16'h0000
`define FCRC_BYTE_MSB    7

// =====================================================================
// Source select and start-up fuse codes
`define FCRC_SRC_BOOTAPP 2'h0
`define FCRC_SRC_BOOT    2'h1
`define FCRC_SRC_FLASH   2'h2
`define FCRC_FUSE_NONE   2'h3

// =====================================================================
// Flash geometry
`define FCRC_FLASH_END   16'h0FFF
`define FCRC_PAGE_LSB    8'h00
`define FCRC_ONE_BYTE    16'h0001
`define FCRC_WORD_ONE    15'h0001
`define FCRC_WORD_ZERO   15'h0000

// =====================================================================
// Timing
`define FCRC_START_DELAY 2'h3
`define FCRC_DELAY_LAST  2'h2
`define FCRC_PH_ISSUE    2'h0
`define FCRC_PH_LOW      2'h1
`define FCRC_PH_HIGH     2'h2

`endif

// File: rtl/fcrc_crc16_byte.v
// One-byte CRC-16 update, most significant bit first
`timescale 1ns/1ps
`include "fcrc_regs.vh"

module fcrc_crc16_byte (
  input  wire [15:0] crc_in,
  input  wire [7:0]  data_in,
  output reg  [15:0] crc_out
);

  integer i;
  reg     fb;

  always @* begin
    crc_out = crc_in;
    fb      = 1'b0;
    for (i = `FCRC_BYTE_MSB; i >= 0; i = i - 1) begin
      fb      = crc_out[15] ^ data_in[i];
      crc_out = {crc_out[14:0], 1'b0} ^ (fb ? `FCRC_POLY : 16'h0000);
    end
  end

endmodule

// File: bench/fcrc_scanner_chk.sv
// Port checker for the flash CRC scanner
`timescale 1ns/1ps
module fcrc_scanner_chk (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        cpu_sleep,
  input wire        flash_rd_en,
  input wire [14:0] flash_word_addr,
  input wire        cpu_stall,
  input wire        cpu_reset_hold,
  input wire        nonmaskable_irq_enable,
  input wire        busy,
  input wire        pass,
  input wire        nmi_req
);
  // ==========================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_stall_busy: assert property (cpu_stall |-> busy)
    else $error("stall without busy");
  chk_fetch_gap: assert property (flash_rd_en |=> !flash_rd_en [*2])
    else $error("fetch gap short");
  chk_fetch_step: assert property (flash_rd_en ##3 flash_rd_en |->
    flash_word_addr == $past(flash_word_addr, 3) + 15'h0001) else $error("address step");
  chk_start_delay: assert property ($rose(busy) && !cpu_reset_hold && !cpu_sleep |->
    !cpu_stall [*3] ##1 (flash_rd_en && flash_word_addr == 15'h0000))
    else $error("start delay");
  chk_pass_stable: assert property (!$fell(busy) |-> $stable(pass))
    else $error("pass moved early");
  chk_nmi_sticky: assert property (nmi_req |=> nmi_req)
    else $error("nmi dropped");
  chk_nmi_cause: assert property ($rose(nmi_req) |->
    $fell(busy) && !pass && nonmaskable_irq_enable) else $error("nmi cause");
  chk_sleep_halt: assert property (cpu_sleep |-> !flash_rd_en)
    else $error("fetch in sleep");
  chk_hang_fail: assert property (cpu_reset_hold && $fell(busy) && !pass |=>
    cpu_reset_hold [*8]) else $error("cpu released");
  cover property ($fell(busy) && pass);
  cover property ($rose(nmi_req));
  cover property (cpu_sleep && cpu_stall);
endmodule
bind fcrc_scanner fcrc_scanner_chk fcrc_scanner_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .cpu_sleep(cpu_sleep), .flash_rd_en(flash_rd_en), .flash_word_addr(flash_word_addr),
  .cpu_stall(cpu_stall), .cpu_reset_hold(cpu_reset_hold), .busy(busy), .pass(pass),
  .nonmaskable_irq_enable(nonmaskable_irq_enable), .nmi_req(nmi_req));

// File: bench/fcrc_flash_model.sv
// Behavioural flash array answering word fetches
`timescale 1ns/1ps
module fcrc_flash_model (
  input  wire        clk_sys,
  input  wire        flash_rd_en,
  input  wire [14:0] flash_word_addr,
  output reg  [15:0] flash_rdata
);
  // ==========================================================
  // Array and read port
  reg [15:0] mem [0:2047];
  initial flash_rdata = 16'h0000;
  // Valid one cycle after a fetch, scrambled otherwise
  always @(posedge clk_sys) begin
    if (flash_rd_en)
      flash_rdata <= mem[flash_word_addr[10:0]];
    else
      flash_rdata <= ~flash_rdata;
  end
endmodule

// File: bench/fcrc_scanner_tb.sv
// Self-checking bench for the flash CRC scanner
`timescale 1ns/1ps
module fcrc_scanner_tb;
  // ==========================================================
  // Stimulus and instances
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg         en_wr = 1'b0, ss_wr = 1'b0, nmi_wr = 1'b0, slp = 1'b0;
  reg  [1:0]  ss_wd = 2'h0, fuse = 2'h3;
  wire        rd_en, stall, hold, en, nmi_en, busy, pass, nmi;
  wire [14:0] addr;
  wire [15:0] rdata;
  wire [1:0]  src;
  integer     n_mismatch = 0, compares = 0, nrd = 0, i, n0, n1;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (rd_en === 1'b1) nrd <= nrd + 1;
  fcrc_scanner fcrc_scanner_inst (.clk_sys(clk_sys), .rst_n(rst_n), .enable_wr(en_wr),
    .source_select_wr(ss_wr), .source_select_wdata(ss_wd), .nmi_enable_wr(nmi_wr),
    .boot_scan_fuse_field(fuse), .boot_end_page(8'h01), .app_end_page(8'h02),
    .cpu_sleep(slp), .flash_rd_en(rd_en), .flash_word_addr(addr), .flash_rdata(rdata),
    .cpu_stall(stall), .cpu_reset_hold(hold), .enable(en), .source_select(src),
    .nonmaskable_irq_enable(nmi_en), .busy(busy), .pass(pass), .nmi_req(nmi));
  fcrc_flash_model fcrc_flash_model_inst (.clk_sys(clk_sys), .flash_rd_en(rd_en),
    .flash_word_addr(addr), .flash_rdata(rdata));
  task chk(input [79:0] nm, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task wait_idle;
    begin
      i = 0;
      while (busy !== 1'b0 && i < 8000) begin
        @(negedge clk_sys);
        i = i + 1;
      end
      if (i == 8000) begin
        n_mismatch = n_mismatch + 1;
        complete_run;
      end
    end
  endtask
  task seal(input [11:0] last, input [15:0] flip);
    reg [15:0] c;
    integer b, k;
    begin
      c = 16'hFFFF;
      for (b = 0; b < last - 1; b = b + 1)
        for (k = 7; k >= 0; k = k - 1)
          c = {c[14:0], 1'b0} ^ ((c[15] ^ fcrc_flash_model_inst.mem[b >> 1][8 * b[0] + k])
            ? 16'h1021 : 16'h0000);
      fcrc_flash_model_inst.mem[last >> 1] = {c[7:0], c[15:8]} ^ flip;
    end
  endtask
  task do_reset(input [1:0] f);
    begin
      @(posedge clk_sys);
      rst_n <= 1'b0;
      fuse <= f;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk_sys);
      wait_idle;
    end
  endtask
  task wr(input a, input b, input c, input [1:0] d);
    begin
      @(posedge clk_sys);
      en_wr <= a;
      ss_wr <= b;
      nmi_wr <= c;
      ss_wd <= d;
      @(posedge clk_sys);
      en_wr <= 1'b0;
      ss_wr <= 1'b0;
      nmi_wr <= 1'b0;
      @(negedge clk_sys);
    end
  endtask
  task t_boot(input [15:0] flip);
    begin
      seal(12'h0FF, flip);
      do_reset(2'h1);
      repeat (10) @(negedge clk_sys);
      chk("stall", 16'h0000, stall);
      chk("pass", {15'h0000, flip == 16'h0000}, pass);
      chk("hold", {15'h0000, flip != 16'h0000}, hold);
      chk("enable", 16'h0001, en);
      chk("source", 16'h0001, src);
      seal(12'h0FF, 16'h0000);
      $display("start-up scan done");
    end
  endtask
  task t_sw(input [1:0] s, input [15:0] words);
    begin
      do_reset(2'h3);
      wr(1'b0, 1'b1, 1'b0, s);
      n0 = nrd;
      wr(1'b1, 1'b0, 1'b0, s);
      chk("busy", 16'h0001, busy);
      wr(1'b0, 1'b1, 1'b0, ~s);
      repeat (30) @(posedge clk_sys);
      slp <= 1'b1;
      @(negedge clk_sys);
      n1 = nrd;
      repeat (20) @(negedge clk_sys);
      chk("stall", 16'h0001, stall);
      chk("sleep rd", n1[15:0], nrd[15:0]);
      @(posedge clk_sys);
      slp <= 1'b0;
      wait_idle;
      chk("pass", 16'h0001, pass);
      chk("source", {14'h0000, s}, src);
      chk("enable", 16'h0001, en);
      chk("words", words, nrd[15:0] - n0[15:0]);
      wr(1'b1, 1'b0, 1'b0, s);
      wait_idle;
      chk("rescan", 16'h0001, pass);
      $display("software scan %0d done", s);
    end
  endtask
  task t_nmi;
    begin
      do_reset(2'h3);
      seal(12'hFFF, 16'h0001);
      wr(1'b0, 1'b1, 1'b0, 2'h1);
      wr(1'b1, 1'b0, 1'b0, 2'h1);
      wait_idle;
      chk("boot pass", 16'h0001, pass);
      wr(1'b0, 1'b0, 1'b1, 2'h0);
      chk("nmi enable", 16'h0001, nmi_en);
      chk("nmi early", 16'h0000, nmi);
      wr(1'b0, 1'b1, 1'b0, 2'h2);
      wr(1'b1, 1'b0, 1'b0, 2'h2);
      wait_idle;
      chk("pass", 16'h0000, pass);
      chk("nmi", 16'h0001, nmi);
      wr(1'b0, 1'b1, 1'b0, 2'h1);
      chk("source", 16'h0002, src);
      wr(1'b1, 1'b0, 1'b0, 2'h1);
      chk("locked", 16'h0000, busy);
      seal(12'hFFF, 16'h0000);
      $display("failing scan done");
    end
  endtask
  initial begin
    for (i = 0; i < 2048; i = i + 1)
      fcrc_flash_model_inst.mem[i] = i * 16'h9E37;
    seal(12'h0FF, 16'h0000);
    seal(12'h1FF, 16'h0000);
    seal(12'hFFF, 16'h0000);
    do_reset(2'h3);
    t_boot(16'h0000);
    t_boot(16'h0100);
    t_sw(2'h0, 16'h0100);
    t_sw(2'h1, 16'h0080);
    t_sw(2'h2, 16'h0800);
    t_sw(2'h3, 16'h0800);
    t_nmi;
    complete_run;
  end
endmodule
